// >>> hw/vcr_regs.sv
// Purpose: Oscillator calibration register bank with its calibration sequencer.
// Assumes: Comparator inputs are synchronous to aclk and valid on every tick.
// Notes: Divider, modulator and output fields are only stored and driven out.
// What the document says about this block
// RULE1: The compare delay sits in word 4 bits 15:8, resets to 10, and is never used below 10.
// RULE2: Software should keep the compare delay above the machine clock over 10 MHz.
// RULE3: Software is advised to use a compare delay of 25 or more when speed matters.
// RULE4: With the amplitude override set, the stored 9-bit final amplitude (reset 128) is used.
// RULE5: The amplitude search starts from the 9-bit start value, which resets to 250.
// RULE6: With the band override set, the stored 8-bit band value (reset 183) is the final band.
// RULE7: The 3-bit core select (reset 7) gives the starting core and the forced core; code 0 is unused.
// RULE8: The core override bit (reset 0) uses the selected core instead of calibrating one.
// RULE9: Word 44 holds output A power, both output power-downs, modulator run and order, order lowest.
// RULE10: The machine clock divider in word 1 bits 2:0 divides by 1, 2, 4 or 8 and resets to 3.
// RULE11: Writing a one to word 0 bit 3 starts a new run with the current override and start settings.
// RULE12: With an override clear, the machine finds that quantity itself and ignores the final value.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
module vcr_regs
	import vcr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic freq_above_target,
	input wire logic amp_above_target,
	output logic [2:0] core_sel_out,
	output logic [7:0] band_out,
	output logic [8:0] amp_out,
	output logic cal_busy,
	output logic cal_done,
	output logic [18:0] feedback_div,
	output logic [31:0] frac_denominator,
	output logic [31:0] frac_numerator,
	output logic [31:0] modulator_seed,
	output logic modulator_seed_en,
	output logic [5:0] detector_delay_sel,
	output logic [5:0] out_a_power_level,
	output logic out_a_pd,
	output logic out_b_pd,
	output logic modulator_run,
	output logic [2:0] modulator_order,
	output logic [1:0] out_a_source_sel,
	output logic [1:0] out_current_boost,
	output logic [5:0] out_b_power_level,
	output logic [1:0] out_b_source_sel
);

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers.

	function automatic logic [SLOT_W:0] slot_of(input logic [AXI_AW-1:0] addr);
		logic [SLOT_W:0] res;
		res = '0;
		for (int i = 0; i < NREG; i++) begin
			if (addr[AXI_AW-1:2] == SLOT_IDX[i]) begin
				res = {1'b1, SLOT_W'(i)};
			end
		end
		return res;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = d[7:0];
		end
		if (strb[1]) begin
			res[15:8] = d[15:8];
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus slave.

	logic wr_en;
	logic [AXI_AW-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [SLOT_W:0] wr_slot;
	logic [SLOT_W:0] rd_slot;
	logic [31:0] rd_data;
	logic [15:0] regs_reg [NREG];

	assign wr_slot = slot_of(wr_addr);
	assign rd_slot = slot_of(s_axi_araddr);
	assign rd_data = rd_slot[SLOT_W] ? {16'h0000, regs_reg[rd_slot[SLOT_W-1:0]]} : 32'h00000000;

	vcr_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_slot[SLOT_W]),
		.rd_data(rd_data),
		.rd_hit(rd_slot[SLOT_W])
	);

	// All twenty words reset to their documented images, fields and fixed bits alike.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NREG; i++) begin
				regs_reg[i] <= SLOT_RST[i]; // [RULE1] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE10]
			end
		end else if (wr_en && wr_slot[SLOT_W]) begin
			regs_reg[wr_slot[SLOT_W-1:0]] <= merge(regs_reg[wr_slot[SLOT_W-1:0]], wr_data, wr_strb);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field views.

	logic [7:0] delay_field;
	logic [7:0] delay_eff;
	logic [2:0] core_field;
	logic [2:0] core_start;
	logic trig_write;

	assign delay_field = regs_reg[S_DELAY][F_DELAY_LO+:8];
	// A value below the floor would let the search settle on the wrong amplitude.
	assign delay_eff = (delay_field < DELAY_MIN) ? DELAY_MIN : delay_field; // [RULE1]
	assign core_field = regs_reg[S_CORE][F_CORE_LO+:3];
	// Code 0 names no core, so it starts from the lowest real one.
	assign core_start = (core_field == 3'h0) ? CORE_MIN : core_field; // [RULE7]
	assign trig_write = wr_en && wr_slot[SLOT_W] && (wr_slot[SLOT_W-1:0] == S_TRIG)
		&& wr_strb[0] && wr_data[F_TRIG]; // [RULE11]

	assign feedback_div = {regs_reg[S_NDIVH][2:0], regs_reg[S_NDIVL]};
	assign frac_denominator = {regs_reg[S_DENH], regs_reg[S_DENL]};
	assign frac_numerator = {regs_reg[S_NUMH], regs_reg[S_NUML]};
	assign modulator_seed = {regs_reg[S_SEEDH], regs_reg[S_SEEDL]};
	assign modulator_seed_en = regs_reg[S_SEEDPFD][F_SEED_EN];
	assign detector_delay_sel = regs_reg[S_SEEDPFD][F_PFD_LO+:6];
	assign out_a_power_level = regs_reg[S_OUTA][F_OUT_A_POWER_LEVEL_LO+:6]; // [RULE9]
	assign out_b_pd = regs_reg[S_OUTA][F_OUTB_PD]; // [RULE9]
	assign out_a_pd = regs_reg[S_OUTA][F_OUTA_PD]; // [RULE9]
	assign modulator_run = regs_reg[S_OUTA][F_MOD_RUN]; // [RULE9]
	assign modulator_order = regs_reg[S_OUTA][2:0]; // [RULE9]
	assign out_a_source_sel = regs_reg[S_OUTSEL][F_OUT_A_SOURCE_SEL_LO+:2];
	assign out_current_boost = regs_reg[S_OUTSEL][F_ISET_LO+:2];
	assign out_b_power_level = regs_reg[S_OUTSEL][5:0];
	assign out_b_source_sel = regs_reg[S_OUTB][1:0];

	////////////////////////////////////////////////////////////////////////////
	// Machine clock enable.

	logic tick;

	vcr_cal_clk_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.div_code(regs_reg[S_CLKDIV][2:0]), // [RULE10]
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////
	// Start request, held until the machine sees a tick.

	logic pend_reg;

	// A write landing on the accepting tick keeps the request alive.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_reg <= 1'b0;
		end else if (trig_write) begin
			pend_reg <= 1'b1; // [RULE11]
		end else if (tick) begin
			pend_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Settings captured at the start of a run.

	logic amp_ovr_reg;
	logic band_ovr_reg;
	logic core_ovr_reg;
	logic [7:0] delay_reg;
	logic start;

	assign start = pend_reg && tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_ovr_reg <= 1'b0;
			band_ovr_reg <= 1'b0;
			core_ovr_reg <= 1'b0;
			delay_reg <= DELAY_MIN;
		end else if (start) begin
			amp_ovr_reg <= regs_reg[S_OVR][F_AMP_OVR]; // [RULE11]
			band_ovr_reg <= regs_reg[S_OVR][F_BAND_OVR];
			core_ovr_reg <= regs_reg[S_CORE][F_CORE_OVR];
			delay_reg <= delay_eff; // [RULE1]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Calibration sequencer: core, then band, then amplitude.

	vcr_state_e state_reg;
	logic [2:0] bit_reg;
	logic [7:0] wait_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			core_sel_out <= CORE_MAX;
			band_out <= 8'h00;
			amp_out <= 9'h000;
			bit_reg <= 3'h0;
			wait_reg <= 8'h00;
		end else if (start) begin
			// A new request restarts the run from any state.
			state_reg <= ST_CORE;
			core_sel_out <= core_start; // [RULE7]
			amp_out <= regs_reg[S_AMPSTRT][8:0]; // [RULE5]
		end else if (tick) begin
			unique case (state_reg)
				ST_IDLE: begin
				end
				ST_CORE: begin
					if (core_ovr_reg) begin
						state_reg <= ST_BAND; // [RULE8]
					end else if (freq_above_target && core_sel_out > CORE_MIN) begin
						core_sel_out <= core_sel_out - 3'h1; // [RULE12]
					end else begin
						state_reg <= ST_BAND;
					end
					band_out <= 8'h80;
					bit_reg <= 3'h7;
				end
				ST_BAND: begin
					wait_reg <= delay_reg;
					if (band_ovr_reg) begin
						band_out <= regs_reg[S_BAND][7:0]; // [RULE6]
						state_reg <= ST_AMP;
					end else begin
						// Successive approximation, one bit per tick, keeps the band search at eight ticks.
						if (!freq_above_target) begin
							band_out[bit_reg] <= 1'b0; // [RULE12]
						end
						if (bit_reg == 3'h0) begin
							state_reg <= ST_AMP;
						end else begin
							band_out[bit_reg-3'h1] <= 1'b1;
							bit_reg <= bit_reg - 3'h1;
						end
					end
				end
				ST_AMP: begin
					if (amp_ovr_reg) begin
						amp_out <= regs_reg[S_AMPFIN][8:0]; // [RULE4]
						state_reg <= ST_DONE;
					end else if (wait_reg > 8'h01) begin
						wait_reg <= wait_reg - 8'h01; // [RULE1]
					end else if (amp_above_target && amp_out != 9'h000) begin
						amp_out <= amp_out - 9'h001; // [RULE12]
						wait_reg <= delay_reg;
					end else begin
						state_reg <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_busy <= 1'b0;
			cal_done <= 1'b0;
		end else if (start) begin
			cal_busy <= 1'b1;
			cal_done <= 1'b0;
		end else if (tick && state_reg == ST_DONE) begin
			cal_busy <= 1'b0;
			cal_done <= 1'b1;
		end
	end

endmodule

// >>> hw/vcr_pkg.sv
// Purpose: Shared constants of the oscillator calibration register bank.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: All registers are 16 bits wide and sit in the low half of a 32-bit word.
package vcr_pkg;

	localparam int AXI_AW = 8;
	localparam int REG_W = 16;
	localparam int NREG = 20;
	localparam int SLOT_W = 5;

	////////////////////////////////////////////////////////////////////////////
	// Register indices.
	localparam logic [5:0] IDX_CAL_TRIGGER_CTRL = 6'h00;
	localparam logic [5:0] IDX_CAL_CLOCK_CTRL = 6'h01;
	localparam logic [5:0] IDX_AMP_CAL_DELAY_CTRL = 6'h04;
	localparam logic [5:0] IDX_CAL_OVERRIDE_CTRL = 6'h08;
	localparam logic [5:0] IDX_AMP_FINAL_VALUE = 6'h10;
	localparam logic [5:0] IDX_AMP_START_VALUE = 6'h11;
	localparam logic [5:0] IDX_BAND_FINAL_VALUE = 6'h13;
	localparam logic [5:0] IDX_CORE_SELECT_CTRL = 6'h14;
	localparam logic [5:0] IDX_FEEDBACK_DIV_HIGH = 6'h22;
	localparam logic [5:0] IDX_FEEDBACK_DIV_LOW = 6'h24;
	localparam logic [5:0] IDX_SEED_ENABLE_PFD_DELAY = 6'h25;
	localparam logic [5:0] IDX_FRAC_DENOMINATOR_HIGH = 6'h26;
	localparam logic [5:0] IDX_FRAC_DENOMINATOR_LOW = 6'h27;
	localparam logic [5:0] IDX_MODULATOR_SEED_HIGH = 6'h28;
	localparam logic [5:0] IDX_MODULATOR_SEED_LOW = 6'h29;
	localparam logic [5:0] IDX_FRAC_NUMERATOR_HIGH = 6'h2A;
	localparam logic [5:0] IDX_FRAC_NUMERATOR_LOW = 6'h2B;
	localparam logic [5:0] IDX_OUT_A_MODULATOR_CTRL = 6'h2C;
	localparam logic [5:0] IDX_OUTPUT_SELECT_POWER = 6'h2D;
	localparam logic [5:0] IDX_OUT_B_SELECT = 6'h2E;

	// Index and reset value of each storage slot, in slot order.
	localparam logic [5:0] SLOT_IDX [NREG] = '{
		IDX_CAL_TRIGGER_CTRL, IDX_CAL_CLOCK_CTRL, IDX_AMP_CAL_DELAY_CTRL,
		IDX_CAL_OVERRIDE_CTRL, IDX_AMP_FINAL_VALUE, IDX_AMP_START_VALUE,
		IDX_BAND_FINAL_VALUE, IDX_CORE_SELECT_CTRL, IDX_FEEDBACK_DIV_HIGH,
		IDX_FEEDBACK_DIV_LOW, IDX_SEED_ENABLE_PFD_DELAY, IDX_FRAC_DENOMINATOR_HIGH,
		IDX_FRAC_DENOMINATOR_LOW, IDX_MODULATOR_SEED_HIGH, IDX_MODULATOR_SEED_LOW,
		IDX_FRAC_NUMERATOR_HIGH, IDX_FRAC_NUMERATOR_LOW, IDX_OUT_A_MODULATOR_CTRL,
		IDX_OUTPUT_SELECT_POWER, IDX_OUT_B_SELECT};
	localparam logic [15:0] SLOT_RST [NREG] = '{
		16'h0000, 16'h0003, 16'h0A43, 16'h2000, 16'h0080, 16'h00FA, 16'h27B7,
		16'hF848, 16'h0000, 16'h0064, 16'h0204, 16'hFFFF, 16'hFFFF, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h1FA0, 16'hC8DF, 16'h07FD};

	localparam logic [4:0] S_TRIG = 5'h00;
	localparam logic [4:0] S_CLKDIV = 5'h01;
	localparam logic [4:0] S_DELAY = 5'h02;
	localparam logic [4:0] S_OVR = 5'h03;
	localparam logic [4:0] S_AMPFIN = 5'h04;
	localparam logic [4:0] S_AMPSTRT = 5'h05;
	localparam logic [4:0] S_BAND = 5'h06;
	localparam logic [4:0] S_CORE = 5'h07;
	localparam logic [4:0] S_NDIVH = 5'h08;
	localparam logic [4:0] S_NDIVL = 5'h09;
	localparam logic [4:0] S_SEEDPFD = 5'h0A;
	localparam logic [4:0] S_DENH = 5'h0B;
	localparam logic [4:0] S_DENL = 5'h0C;
	localparam logic [4:0] S_SEEDH = 5'h0D;
	localparam logic [4:0] S_SEEDL = 5'h0E;
	localparam logic [4:0] S_NUMH = 5'h0F;
	localparam logic [4:0] S_NUML = 5'h10;
	localparam logic [4:0] S_OUTA = 5'h11;
	localparam logic [4:0] S_OUTSEL = 5'h12;
	localparam logic [4:0] S_OUTB = 5'h13;

	////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int F_TRIG = 3;
	localparam int F_DELAY_LO = 8;
	localparam int F_AMP_OVR = 14;
	localparam int F_BAND_OVR = 11;
	localparam int F_CORE_LO = 11;
	localparam int F_CORE_OVR = 10;
	localparam int F_SEED_EN = 15;
	localparam int F_PFD_LO = 8;
	localparam int F_OUT_A_POWER_LEVEL_LO = 8;
	localparam int F_OUTB_PD = 7;
	localparam int F_OUTA_PD = 6;
	localparam int F_MOD_RUN = 5;
	localparam int F_OUT_A_SOURCE_SEL_LO = 11;
	localparam int F_ISET_LO = 9;

	localparam logic [7:0] DELAY_MIN = 8'h0A;
	localparam logic [2:0] CORE_MIN = 3'h1;
	localparam logic [2:0] CORE_MAX = 3'h7;
	localparam logic [2:0] CLKDIV_MAX = 3'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {ST_IDLE, ST_CORE, ST_BAND, ST_AMP, ST_DONE} vcr_state_e;

endpackage

// >>> hw/vcr_cal_clk_div.sv
// Purpose: Enable pulse for the calibration machine, reference divided by 1, 2, 4 or 8.
// Assumes: Codes above the largest divide setting act as the largest.
// Notes: The pulse is one aclk cycle wide at divide 2, 4 or 8 and stays high at divide 1.
module vcr_cal_clk_div
	import vcr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] div_code,
	output logic tick
);

	logic [2:0] cnt_reg;
	logic [2:0] code;
	logic [2:0] last;

	assign code = (div_code > CLKDIV_MAX) ? CLKDIV_MAX : div_code;
	assign last = 3'((4'h1 << code) - 4'h1);
	assign tick = (cnt_reg >= last);

	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end

endmodule

// >>> hw/vcr_axil_slave.sv
// Purpose: AXI4-Lite slave handshake for the register bank.
// Assumes: Address and write data may arrive in either order.
// Notes: Read data and error come combinationally from the decoder.
module vcr_axil_slave
	import vcr_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en,
	output logic [AXI_AW-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit
);

	logic aw_have_reg;
	logic w_have_reg;

	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	assign wr_en = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end else if (wr_en) begin
				aw_have_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end else if (wr_en) begin
				w_have_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_en) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// >>> sim/vcr_regs_props.sv
// Purpose: Concurrent checks on the ports of the calibration register bank.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes: Bound to every instance of the top module.
module vcr_regs_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [2:0] core_sel_out,
	input wire logic [7:0] band_out,
	input wire logic cal_busy,
	input wire logic cal_done
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before rready");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready high with rvalid");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during bvalid");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	decerr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
		else $error("unmapped read returned data");
	reset_image_a: assert property ($rose(aresetn) |-> core_sel_out == 3'h7 && band_out == 8'h00 && !cal_busy)
		else $error("outputs wrong after reset");
	busy_excl_a: assert property (cal_busy |-> !cal_done) else $error("busy and done together");
	done_cause_a: assert property ($rose(cal_done) |-> $past(cal_busy)) else $error("done without a run");
	core_legal_a: assert property (cal_busy |-> core_sel_out != 3'h0) else $error("unused core code in run");

	cover property ($rose(cal_done));
	cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h3);
endmodule

bind vcr_regs vcr_regs_props u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.core_sel_out(core_sel_out), .band_out(band_out), .cal_busy(cal_busy), .cal_done(cal_done));

// >>> sim/vcr_regs_tb.sv
// Purpose: Self-checking bench for the calibration register bank.
// Assumes: Bus tasks sample at the falling edge and act at the rising edge.
// Notes: Calibration runs use divide codes 0 and 1 to keep runs short.
module vcr_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'h0, aresetn = 1'h0, freq_above_target = 1'h0, amp_above_target = 1'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, band_out;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, frac_denominator, frac_numerator, modulator_seed;
	logic [3:0] s_axi_wstrb = 4'h3;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cal_busy, cal_done;
	logic modulator_seed_en, out_a_pd, out_b_pd, modulator_run;
	logic [1:0] s_axi_bresp, s_axi_rresp, out_a_source_sel, out_current_boost, out_b_source_sel;
	logic [2:0] core_sel_out, modulator_order;
	logic [8:0] amp_out;
	logic [18:0] feedback_div;
	logic [5:0] detector_delay_sel, out_a_power_level, out_b_power_level;
	int err_count = 0, checks_done = 0;
	localparam logic [7:0] RA [14] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h40, 8'h44, 8'h4C, 8'h50, 8'h90, 8'h94, 8'h98,
		8'hB0, 8'hB4, 8'hB8};
	localparam logic [15:0] RV [14] = '{16'h0000, 16'h0003, 16'h0A43, 16'h2000, 16'h0080, 16'h00FA, 16'h27B7,
		16'hF848, 16'h0064, 16'h0204, 16'hFFFF, 16'h1FA0, 16'hC8DF, 16'h07FD};

	vcr_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.freq_above_target(freq_above_target), .amp_above_target(amp_above_target), .core_sel_out(core_sel_out),
		.band_out(band_out), .amp_out(amp_out), .cal_busy(cal_busy), .cal_done(cal_done),
		.feedback_div(feedback_div), .frac_denominator(frac_denominator), .frac_numerator(frac_numerator),
		.modulator_seed(modulator_seed), .modulator_seed_en(modulator_seed_en),
		.detector_delay_sel(detector_delay_sel), .out_a_power_level(out_a_power_level), .out_a_pd(out_a_pd),
		.out_b_pd(out_b_pd), .modulator_run(modulator_run), .modulator_order(modulator_order),
		.out_a_source_sel(out_a_source_sel), .out_current_boost(out_current_boost),
		.out_b_power_level(out_b_power_level), .out_b_source_sel(out_b_source_sel));

	////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (err_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Handshakes are judged at the falling edge, where nothing is changing, and acted on at the next rising edge.
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		logic aw_hit, w_hit, b_hit;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (int n = 0; n < 40; n++) begin
			@(negedge aclk);
			aw_hit = s_axi_awvalid && s_axi_awready;
			w_hit = s_axi_wvalid && s_axi_wready;
			b_hit = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_hit) s_axi_awvalid <= 1'h0;
			if (w_hit) s_axi_wvalid <= 1'h0;
			if (b_hit) begin
				s_axi_bready <= 1'h0;
				return;
			end
		end
		err_count++;
		close_out();
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_hit, r_hit;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (int n = 0; n < 40; n++) begin
			@(negedge aclk);
			ar_hit = s_axi_arvalid && s_axi_arready;
			r_hit = (s_axi_rvalid === 1'h1);
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar_hit) s_axi_arvalid <= 1'h0;
			if (r_hit) begin
				s_axi_rready <= 1'h0;
				return;
			end
		end
		err_count++;
		close_out();
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [1:0] r;
		axi_wr(a, d, r);
		check(r, 2'h0);
	endtask

	// Counts the cycles with cal_busy high; a done flag left from the previous run is skipped.
	task automatic run_cal(output int cyc);
		wr(8'h00, 16'h0008);
		cyc = 0;
		for (int n = 0; n < 4000; n++) begin
			@(negedge aclk);
			if (cal_busy === 1'h1) cyc++;
			if (cal_done === 1'h1 && cyc > 0) return;
		end
		err_count++;
		close_out();
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #2 aclk = ~aclk;
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int c0, c1, c2;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		@(negedge aclk);
		check({out_a_power_level, out_b_pd, out_a_pd, modulator_run, modulator_order}, 12'h7E8);
		check({core_sel_out, feedback_div, frac_denominator[7:0]}, {3'h7, 19'h64, 8'hFF});
		check({modulator_seed_en, detector_delay_sel, out_a_source_sel, out_current_boost, out_b_power_level,
			out_b_source_sel, frac_denominator[31:16]}, {1'h0, 6'h02, 2'h1, 2'h0, 6'h1F, 2'h1, 16'hFFFF});
		check({modulator_seed[15:0], frac_numerator[31:16]}, 32'h0);
		for (int i = 0; i < 14; i++) begin
			axi_rd(RA[i], d, r);
			check({r, d}, {2'h0, 16'h0000, RV[i]});
		end
		axi_rd(8'h08, d, r);
		check({r, d}, {2'h3, 32'h0});
		axi_wr(8'h0C, 16'h1234, r);
		check(r, 2'h3);
		wr(8'hB0, 16'h15A3);
		wr(8'hA0, 16'h1357);
		wr(8'hAC, 16'h2468);
		@(negedge aclk);
		check({out_a_power_level, out_b_pd, out_a_pd, modulator_run, modulator_order}, {6'h15, 6'h2B});
		check({modulator_seed[31:16], frac_numerator[15:0]}, 32'h13572468);
		// Both comparators say above so that an ignored override would visibly move the outputs.
		@(posedge aclk);
		freq_above_target <= 1'h1;
		amp_above_target <= 1'h1;
		wr(8'h04, 16'h0000);
		wr(8'h40, 16'h0155);
		wr(8'h4C, 16'h275A);
		wr(8'h50, 16'hDC48);
		wr(8'h20, 16'h6800);
		run_cal(c0);
		check({core_sel_out, band_out, amp_out}, {3'h3, 8'h5A, 9'h155});
		@(posedge aclk);
		freq_above_target <= 1'h0;
		amp_above_target <= 1'h0;
		wr(8'h20, 16'h2000);
		wr(8'h50, 16'hE848);
		wr(8'h44, 16'h0123);
		run_cal(c0);
		check({core_sel_out, band_out, amp_out}, {3'h5, 8'h00, 9'h123});
		wr(8'h10, 16'h0543);
		axi_rd(8'h10, d, r);
		check(d, 32'h0543);
		run_cal(c1);
		check(c1 >= c0 - 3 && c1 <= c0 + 3, 1'h1);
		wr(8'h04, 16'h0001);
		// A delay of 25 ticks keeps the machine clock over 10 MHz rule at this divide and adds 15 ticks per run.
		wr(8'h10, 16'h1943);
		run_cal(c2);
		check(c2 >= 2 * c0 + 26 && c2 <= 2 * c0 + 38, 1'h1);
		close_out();
	end
endmodule
